// File: logic/cst_core.sv
// Purpose: status word, operand register, stack pointer, state timing and address decode
// Assumes: the alu, ram arrays and bus drivers sit outside; requests arrive on clock
// Notes: phase 1 is the high half of clock, phase 2 the low half; strobes are state-resolved
//   the fetch-select pin is synchronised, so externalFetch trails the pin by three edges
//   the on-chip disable is sticky; only reset sets it again
// Function
// - status word at special address D0; fields carry down to parity.
// - bank-select pair picks bank base 00, 08, 10 or 18.
// - parity flag is odd count of ones in the accumulator.
// - carry and overflow from arithmetic, nibble carry from decimal operations.
// - operand register is multiply/divide source and destination, else scratch.
// - stack pointer is 8 bits, incremented before each pushed byte.
// - stack pointer decremented after each popped byte.
// - stack pointer resets to 07; software reads and writes it.
// - machine cycle is six states, one clock each, two phases each.
// - arithmetic in phase one, register transfers in phase two.
// - address latch strobe twice per cycle, from S1 end and S4 end.
// - opcode latched in S1, second byte in S4, completion at S6 end.
// - one-byte instruction discards the S4 fetch, no program counter step.
// - external fetch select low forces every fetch to external memory.
// - lower RAM direct or indirect, upper RAM indirect, special registers direct.
// - banks at 00-1F, bit-addressable bytes at 20-2F.
// - stack may sit anywhere in internal RAM, up to 256 bytes.
// - external data space is 64 Kbyte with 16- or 8-bit addresses.
// - ext data moves at F700-FFFF steered by the on-chip disable.
// - while on-chip disable is set, every ext data move goes external.
// - F700-F7FF decode as CAN registers, F800-FFFF as extended RAM.
`timescale 1ns/1ps
module cst_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] accValue,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrite,
  input wire logic aluFlagWrite,
  input wire logic aluCarry,
  input wire logic aluOverflow,
  input wire logic bcdFlagWrite,
  input wire logic aluNibbleCarry,
  input wire logic mulDivWrite,
  input wire logic [7:0] mulDivResult,
  input wire cst_pkg::cst_stk_t stackOp,
  input wire logic twoByteInstr,
  input wire logic extFetchSelectPin,
  input wire logic [7:0] dataAddr,
  input wire logic indirectAccess,
  input wire logic [15:0] extDataAddr,
  input wire logic extDataAccess,
  input wire logic onchipXdataDisableClear,
  output logic [7:0] programStatusWord,
  output logic [7:0] stackPointer,
  output logic [7:0] operandReg,
  output logic [7:0] sfrRdData,
  output logic [7:0] stackWrAddr,
  output logic [4:0] bankBase,
  output logic addrLatchStrobe,
  output logic opcodeLatch,
  output logic operandLatch,
  output logic pcAdvance,
  output logic instrDone,
  output logic externalFetch,
  output logic [5:0] cycleState,
  output logic selLowerRam,
  output logic selUpperRam,
  output logic selSfr,
  output logic selBitArea,
  output logic selCanRegs,
  output logic selXram,
  output logic selExtBus,
  output logic onchipXdataDisable
);
  import cst_pkg::*;

  cst_state_t state_ff, nxt_state;
  logic [7:0] psw_ff, nxt_psw;
  logic [7:0] sp_ff, nxt_sp;
  logic [7:0] b_ff, nxt_b;
  logic [7:0] rd_ff, nxt_rd;
  logic [7:0] stkAddr_ff;
  logic [4:0] bank_ff;
  logic ale_ff, opl_ff, opnd_ff, pca_ff, done_ff, extf_ff;
  logic lo_ff, up_ff, sfr_ff, bit_ff, can_ff, xr_ff, ext_ff, xdis_ff;
  logic eaMeta_ff, eaSync_ff;

  // state sequence: six states of one oscillator period each
  always_comb begin
    case (state_ff)
      ST_S1: nxt_state = ST_S2;
      ST_S2: nxt_state = ST_S3;
      ST_S3: nxt_state = ST_S4;
      ST_S4: nxt_state = ST_S5;
      ST_S5: nxt_state = ST_S6;
      ST_S6: nxt_state = ST_S1;
      default: nxt_state = ST_S1;
    endcase
  end

  // phase 1 work happens on the state edge, phase 2 transfers on the same registers
  wire inS1 = (state_ff == ST_S1);
  wire inS4 = (state_ff == ST_S4);
  wire inS6 = (state_ff == ST_S6);
  wire boundary = inS6;
  // strobes are registered, so each shows in the state after the one that decodes it
  wire aleNext = inS1 | inS4;
  wire pcStepNext = inS1 | (inS4 & twoByteInstr);

  // parity follows the live accumulator
  wire parityNow = ^accValue;

  // special register writes
  wire wrPsw = sfrWrite & (sfrAddr == PSW_ADDR);
  wire wrSp = sfrWrite & (sfrAddr == SP_ADDR);
  wire wrB = sfrWrite & (sfrAddr == B_ADDR);

  // status word next value: software write, then alu flags, parity always live
  // a write to the parity bit is dropped: hardware rewrites it from the accumulator on every clock
  always_comb begin
    nxt_psw = psw_ff;
    if (wrPsw) begin
      nxt_psw = sfrWrData;
    end
    if (aluFlagWrite) begin
      nxt_psw[CY_BIT] = aluCarry;
      nxt_psw[OV_BIT] = aluOverflow;
    end
    if (bcdFlagWrite) begin
      nxt_psw[AC_BIT] = aluNibbleCarry;
    end
    nxt_psw[PAR_BIT] = parityNow;
  end

  // stack pointer: pre-increment push, post-decrement pop, wraps in 256 bytes
  // an explicit pointer write beats a push or pop in the same cycle
  wire [7:0] spInc = sp_ff + 8'h01;
  wire [7:0] spDec = sp_ff - 8'h01;
  always_comb begin
    if (wrSp) begin
      nxt_sp = sfrWrData;
    end else if (stackOp == STK_PUSH) begin
      nxt_sp = spInc;
    end else if (stackOp == STK_POP) begin
      nxt_sp = spDec;
    end else begin
      nxt_sp = sp_ff;
    end
  end
  wire [7:0] stkAddrNext = (stackOp == STK_PUSH) ? spInc : sp_ff;

  // operand register: multiply/divide result has priority over a plain write
  assign nxt_b = mulDivWrite ? mulDivResult : (wrB ? sfrWrData : b_ff);

  // register read-back
  assign nxt_rd = (sfrAddr == PSW_ADDR) ? {psw_ff[7:1], parityNow} :
                  (sfrAddr == SP_ADDR) ? sp_ff :
                  (sfrAddr == B_ADDR) ? b_ff : 8'h00;

  // internal data decode: upper half needs indirect, special registers need direct
  wire isUpper = (dataAddr >= UPPER_BASE);
  wire loSel = ~isUpper;
  wire upSel = isUpper & indirectAccess;
  wire sfrSel = isUpper & ~indirectAccess;
  wire bitSel = (dataAddr >= BITAREA_LO) & (dataAddr <= BITAREA_HI);
  // bank base moves with the status word, so the next instruction sees the new bank
  wire [4:0] bankNext = {nxt_psw[RSH_BIT], nxt_psw[RSL_BIT], 3'h0};

  // external data decode over the 64 Kbyte space
  wire inCan = (extDataAddr >= CAN_LO) & (extDataAddr <= CAN_HI);
  wire inXram = (extDataAddr >= ONCHIP_EXTENDED_RAM_LO);
  // the CAN window and extended RAM answer only once the disable is cleared
  wire onchipOk = ~xdis_ff & extDataAccess;
  wire canSel = onchipOk & inCan;
  wire xrSel = onchipOk & inXram;
  wire extSel = extDataAccess & ~(canSel | xrSel);

  // disable bit: set only by reset, cleared once by software
  // no logic path sets it again, so a stray write cannot cut off the on-chip space
  wire xdisNext = xdis_ff & ~onchipXdataDisableClear;

  // pin synchroniser for the fetch select
  // the first stage may go metastable; only the second stage is read
  always_ff @(posedge clock) begin
    eaMeta_ff <= extFetchSelectPin;
    eaSync_ff <= eaMeta_ff;
  end

  // machine-cycle state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_S1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // status word and stack pointer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      psw_ff <= PSW_RESET;
      sp_ff <= SP_RESET;
    end else begin
      psw_ff <= nxt_psw;
      sp_ff <= nxt_sp;
    end
  end

  // operand register, read-back and on-chip disable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      b_ff <= 8'h00;
      rd_ff <= 8'h00;
      xdis_ff <= 1'b1;
    end else begin
      b_ff <= nxt_b;
      rd_ff <= nxt_rd;
      xdis_ff <= xdisNext;
    end
  end

  // cycle strobes: address latch, opcode latch, completion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ale_ff <= 1'b0;
      opl_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      ale_ff <= aleNext;
      opl_ff <= inS1;
      done_ff <= boundary;
    end
  end

  // fetch strobes: second byte, counter step, fetch source
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      opnd_ff <= 1'b0;
      pca_ff <= 1'b0;
      extf_ff <= 1'b0;
    end else begin
      opnd_ff <= inS4 & twoByteInstr;
      pca_ff <= pcStepNext;
      extf_ff <= ~eaSync_ff;
    end
  end

  // internal data decode outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stkAddr_ff <= SP_RESET;
      bank_ff <= 5'h00;
      lo_ff <= 1'b0;
      up_ff <= 1'b0;
      sfr_ff <= 1'b0;
      bit_ff <= 1'b0;
    end else begin
      stkAddr_ff <= stkAddrNext;
      bank_ff <= bankNext;
      lo_ff <= loSel;
      up_ff <= upSel;
      sfr_ff <= sfrSel;
      bit_ff <= bitSel;
    end
  end

  // external data decode outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      can_ff <= 1'b0;
      xr_ff <= 1'b0;
      ext_ff <= 1'b0;
    end else begin
      can_ff <= canSel;
      xr_ff <= xrSel;
      ext_ff <= extSel;
    end
  end

  // register state straight to the ports
  assign programStatusWord = psw_ff;
  assign stackPointer = sp_ff;
  assign operandReg = b_ff;
  assign sfrRdData = rd_ff;
  assign stackWrAddr = stkAddr_ff;
  assign bankBase = bank_ff;

  // timing strobes to the ports
  assign addrLatchStrobe = ale_ff;
  assign opcodeLatch = opl_ff;
  assign operandLatch = opnd_ff;
  assign pcAdvance = pca_ff;
  assign instrDone = done_ff;
  assign externalFetch = extf_ff;
  assign cycleState = state_ff;

  // decode selects to the ports
  assign selLowerRam = lo_ff;
  assign selUpperRam = up_ff;
  assign selSfr = sfr_ff;
  assign selBitArea = bit_ff;
  assign selCanRegs = can_ff;
  assign selXram = xr_ff;
  assign selExtBus = ext_ff;
  assign onchipXdataDisable = xdis_ff;
endmodule

// File: logic/cst_pkg.sv
// Purpose: constants for the cpu status, timing and memory-map block
// Assumes: 100 MHz oscillator clock, one state per clock
// Notes: addresses and field positions of the status word and stack
package cst_pkg;
  localparam logic [7:0] PSW_ADDR = 8'hD0;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] B_ADDR = 8'hF0;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int F0_BIT = 5;
  localparam int RSH_BIT = 4;
  localparam int RSL_BIT = 3;
  localparam int OV_BIT = 2;
  localparam int F1_BIT = 1;
  localparam int PAR_BIT = 0;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BITAREA_LO = 8'h20;
  localparam logic [7:0] BITAREA_HI = 8'h2F;
  localparam logic [15:0] CAN_LO = 16'hF700;
  localparam logic [15:0] CAN_HI = 16'hF7FF;
  localparam logic [15:0] ONCHIP_EXTENDED_RAM_LO = 16'hF800;
  // machine-cycle states, one-hot
  typedef enum logic [5:0] {
    ST_S1 = 6'h01,
    ST_S2 = 6'h02,
    ST_S3 = 6'h04,
    ST_S4 = 6'h08,
    ST_S5 = 6'h10,
    ST_S6 = 6'h20
  } cst_state_t;
  // stack operation requests
  typedef enum logic [1:0] {
    STK_NONE = 2'h0,
    STK_PUSH = 2'h1,
    STK_POP = 2'h2
  } cst_stk_t;
endpackage

// File: sim/cst_checker.sv
// Purpose: assertions on the status, stack, timing and decode ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every core instance
`timescale 1ns/1ps
module cst_checker
  import cst_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] accValue,
  input wire logic sfrWrite,
  input wire cst_pkg::cst_stk_t stackOp,
  input wire logic twoByteInstr,
  input wire logic extDataAccess,
  input wire logic [7:0] programStatusWord,
  input wire logic [7:0] stackPointer,
  input wire logic [7:0] stackWrAddr,
  input wire logic [4:0] bankBase,
  input wire logic addrLatchStrobe,
  input wire logic opcodeLatch,
  input wire logic operandLatch,
  input wire logic pcAdvance,
  input wire logic instrDone,
  input wire logic [5:0] cycleState,
  input wire logic selExtBus,
  input wire logic onchipXdataDisable
);
  // all checks on the one clock, muted in reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  strobe_pair_a: assert property (addrLatchStrobe == (cycleState == ST_S2 || cycleState == ST_S5))
    else $error("address strobe outside S2 or S5");
  state_ring_a: assert property (cycleState == ST_S1 |=> cycleState == ST_S2 ##4 cycleState == ST_S6 ##1 instrDone)
    else $error("machine cycle not six states");
  opcode_s2_a: assert property (opcodeLatch == (cycleState == ST_S2))
    else $error("opcode latch at wrong state");
  second_byte_a: assert property (cycleState == ST_S4 && twoByteInstr |=> operandLatch && pcAdvance)
    else $error("second byte not taken");
  discard_fetch_a: assert property (cycleState == ST_S4 && !twoByteInstr |=> !operandLatch && !pcAdvance)
    else $error("discarded fetch advanced the counter");
  push_pre_a: assert property (stackOp == STK_PUSH && !sfrWrite |=>
    stackPointer == $past(stackPointer) + 8'h01 && stackWrAddr == stackPointer)
    else $error("push did not pre-increment");
  pop_post_a: assert property (stackOp == STK_POP && !sfrWrite |=>
    stackPointer == $past(stackPointer) - 8'h01 && stackWrAddr == $past(stackPointer))
    else $error("pop did not post-decrement");
  parity_flag_a: assert property ($past(rst_n) |-> programStatusWord[0] == ^$past(accValue))
    else $error("parity flag wrong");
  bank_map_a: assert property (bankBase == {programStatusWord[4:3], 3'h0})
    else $error("bank base wrong");
  ext_route_a: assert property (extDataAccess && onchipXdataDisable |=> selExtBus)
    else $error("move not sent to external bus");
  // main scenarios reached
  cover property (stackOp == STK_PUSH);
  cover property (extDataAccess && !onchipXdataDisable);
  cover property (cycleState == ST_S4 && twoByteInstr);
endmodule
bind cst_core cst_checker i_cst_checker (.*);

// File: sim/cst_ext_mem.sv
// Purpose: far side of the external program and data memory bus
// Assumes: strapping of the fetch-select pin set by the bench
// Notes: the pin has a pull-up, so it idles high
`timescale 1ns/1ps
module cst_ext_mem (
  input wire logic clock,
  input wire logic strapLow,
  input wire logic selExtBus,
  output logic extFetchSelectPin,
  output int busCycles
);
  int busCount_ff = 0;
  // strapped low means all fetches go external
  assign extFetchSelectPin = !strapLow;
  assign busCycles = busCount_ff;
  // one external data bus cycle per routed move
  always @(posedge clock) if (selExtBus) busCount_ff <= busCount_ff + 1;
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the cpu status, timing and decode block
// Assumes: inputs change at the falling edge, outputs settle after the rising one
// Notes: the driver queues output expectations, a monitor compares them; the disable and bus-count checks run inline
`timescale 1ns/1ps
module testbench;
  import cst_pkg::*;
  logic clock = 0, rst_n = 0, sfrWrite = 0, aluFlagWrite = 0, aluCarry = 0, aluOverflow = 0, bcdFlagWrite = 0;
  logic aluNibbleCarry = 0, mulDivWrite = 0, twoByteInstr = 0, indirectAccess = 0, extDataAccess = 0, strapLow = 0;
  logic onchipXdataDisableClear = 0;
  logic [7:0] accValue = 0, sfrAddr = 0, sfrWrData = 0, mulDivResult = 0, dataAddr = 0, v;
  logic [15:0] extDataAddr = 0;
  logic [15:0] extAddrs [5] = '{16'hF6FF, 16'hF700, 16'hF7FF, 16'hF800, 16'hFFFF};
  cst_stk_t stackOp = STK_NONE;
  logic [7:0] programStatusWord, stackPointer, operandReg, sfrRdData, stackWrAddr;
  logic [4:0] bankBase;
  logic [5:0] cycleState;
  logic addrLatchStrobe, opcodeLatch, operandLatch, pcAdvance, instrDone, externalFetch, selLowerRam, selUpperRam;
  logic selSfr, selBitArea, selCanRegs, selXram, selExtBus, onchipXdataDisable, extFetchSelectPin;
  logic [15:0] expQ[$];
  int selQ[$];
  int error_cnt = 0, check_count = 0, cyc = 0, n, busCycles;
  cst_core i_cst_core (.*);
  cst_ext_mem i_cst_ext_mem (.clock, .strapLow, .selExtBus, .extFetchSelectPin, .busCycles);
  // 100 MHz clock
  always #5 clock = ~clock;
  // picks the output a note refers to
  function automatic logic [15:0] seen(int s);
    case (s)
      0: return {8'h00, programStatusWord};
      1: return {8'h00, stackPointer};
      2: return {8'h00, operandReg};
      3: return {8'h00, sfrRdData};
      4: return {8'h00, stackWrAddr};
      5: return {11'h000, bankBase};
      6: return {12'h000, selLowerRam, selUpperRam, selSfr, selBitArea};
      7: return {15'h0000, externalFetch};
      default: return {13'h0000, selCanRegs, selXram, selExtBus};
    endcase
  endfunction
  task automatic check(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // oldest note compared once its result has landed
  always @(posedge clock) if (selQ.size() > 0) begin
    #1;
    check(seen(selQ.pop_front()), expQ.pop_front());
  end
  task automatic note(int s, logic [15:0] e);
    selQ.push_back(s);
    expQ.push_back(e);
  endtask
  // one operation: note, one edge, drop the pulses, idle a cycle
  task automatic go(int s, logic [15:0] e);
    note(s, e);
    @(negedge clock);
    {sfrWrite, aluFlagWrite, bcdFlagWrite, mulDivWrite, extDataAccess, onchipXdataDisableClear} = 6'h00;
    stackOp = STK_NONE;
    twoByteInstr = 1'($urandom);
    @(negedge clock);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, int s, logic [15:0] e);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1;
    go(s, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  // main sequence
  initial begin
    void'($urandom(63));
    repeat (8) @(negedge clock);
    rst_n = 1;
    go(1, 16'(SP_RESET));
    go(0, 16'(PSW_RESET));
    check(onchipXdataDisable, 1);
    $display("reset test done");
    n = 1 + $urandom % 6;
    stackOp = STK_PUSH;
    for (int i = 1; i <= n; i++) begin
      note(1, 16'(SP_RESET + i));
      @(negedge clock);
    end
    stackOp = STK_POP;
    note(4, 16'(SP_RESET + n));
    go(1, 16'(SP_RESET + n - 1));
    wr(SP_ADDR, 8'hFF, 1, 16'h00FF);
    stackOp = STK_PUSH;
    go(4, 16'h0000);
    sfrAddr = SP_ADDR;
    go(3, 16'h0000);
    $display("stack test done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[4:3] = 2'(i);
      accValue = 8'($urandom);
      wr(PSW_ADDR, v, 0, {8'h00, v[7:1], ^accValue});
      go(5, 16'(i * 8));
    end
    aluFlagWrite = 1;
    aluCarry = 1'($urandom);
    aluOverflow = ~aluCarry;
    bcdFlagWrite = 1;
    aluNibbleCarry = aluCarry;
    go(0, {8'h00, aluCarry, aluCarry, v[5:3], aluOverflow, v[1], ^accValue});
    mulDivWrite = 1;
    mulDivResult = 8'($urandom);
    go(2, {8'h00, mulDivResult});
    sfrAddr = B_ADDR;
    go(3, {8'h00, mulDivResult});
    sfrAddr = 8'hA5;
    go(3, 16'h0000);
    $display("status test done");
    for (int i = 0; i < 8; i++) begin
      dataAddr = (i < 2) ? 8'(8'h2F + i) : 8'($urandom);
      indirectAccess = 1'($urandom);
      go(6, {12'h000, !dataAddr[7], dataAddr[7] & indirectAccess, dataAddr[7] & !indirectAccess,
        dataAddr[7:4] == 4'h2});
    end
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        extDataAccess = 1;
        extDataAddr = extAddrs[i];
        go(8, {13'h0000, j && extDataAddr[15:8] == 8'hF7, j && extDataAddr >= ONCHIP_EXTENDED_RAM_LO,
          !j || extDataAddr < CAN_LO});
      end
      onchipXdataDisableClear = 1;
      go(8, 16'h0000);
    end
    check(onchipXdataDisable, 0);
    check(16'(busCycles), 16'd6);
    $display("decode test done");
    strapLow = 1;
    repeat (3) @(negedge clock);
    go(7, 16'h0001);
    $display("fetch test done");
    repeat (2) @(negedge clock);
    results();
  end
endmodule
